/* File: common/pmr_pkg.sv */
// Package: register map, field layout, reset values and bus carriers for the power management register bank
package pmr_pkg;

   // Byte addresses within page zero
   localparam logic [15:0] ADDR_WIN_LO   = 16'h0048;
   localparam logic [15:0] ADDR_WIN_HI   = 16'h004C;
   localparam logic [15:0] ADDR_ANALOG   = 16'h0048;
   localparam logic [15:0] ADDR_DIGITAL  = 16'h0049;
   localparam logic [15:0] ADDR_BATTERY  = 16'h004A;
   localparam logic [15:0] ADDR_IRQ_STAT = 16'h004B;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h004C;

   // Analog regulator register fields
   localparam int ANA_FORCE_BIT = 5;
   localparam int ANA_ON_BIT    = 4;
   localparam logic       ANA_FORCE_RST = 1'h1;
   localparam logic       ANA_ON_RST    = 1'h0;
   localparam logic [3:0] ANA_TRIM_RST  = 4'h3;

   // Digital regulator register fields
   localparam int DIG_WAKE_BIT  = 7;
   localparam int DIG_ON_BIT    = 4;
   localparam int DIG_KEEP_BIT  = 1;
   localparam logic       DIG_KEEP_RST = 1'h1;
   localparam logic [1:0] DIG_TRIM_RST = 2'h0;

   // Battery end-of-life register fields
   localparam int BAT_ABOVE_BIT = 7;
   localparam int BAT_ON_BIT    = 5;
   localparam logic       BAT_ON_RST  = 1'h0;
   localparam logic [4:0] BAT_THR_RST = 5'h00;

   // Interrupt status bits: wake-up edge, battery drop, digital regulator off
   localparam int IRQ_WAKE_BIT = 0;
   localparam int IRQ_BAT_BIT  = 1;
   localparam int IRQ_DOFF_BIT = 2;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [15:0] adr;
      logic [7:0]  dat;
   } pmr_wb_req_t;

   typedef struct packed {
      logic       ack;
      logic [7:0] dat;
   } pmr_wb_rsp_t;

   typedef struct packed {
      logic       ana_on;
      logic       ana_force;
      logic [3:0] ana_trim;
      logic       dig_keep;
      logic [1:0] dig_trim;
      logic       bat_on;
      logic [4:0] bat_thr;
   } pmr_ctrl_t;

endpackage

/* File: design/pmr_regs.sv */
// Power management control and status register bank, Wishbone slave
`timescale 1ns/1ps

module pmr_regs
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Wishbone slave, 8-bit data
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [15:0]          wb_adr_i,
   input  wire logic [0:0]           wb_sel_i,
   input  wire logic [7:0]           wb_dat_i,
   output logic                      wb_ack_o,
   output logic [7:0]                wb_dat_o,
   // Analog side
   input  wire logic                 wakeup_pin,
   input  wire logic                 digital_regulator_on_in,
   input  wire logic                 battery_comparator_in,
   output pmr_pkg::pmr_ctrl_t        ctrl,
   // Interrupt
   output logic                      irq
);

   logic       rst_meta;
   logic       rst_sync_n;
   logic [1:0] wake_sync;
   logic [1:0] don_sync;
   logic [1:0] bat_sync;
   logic       wake_q;
   logic       bat_q;
   logic       don_q;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [2:0] events;
   logic       hit;
   logic       wr;
   logic       rd;
   logic [7:0] next_rdata;
   // Per-register strobes
   logic       wr_ana;
   logic       wr_dig;
   logic       wr_bat;
   logic       wr_mask;
   logic       rd_stat;
   logic       next_ack;
   logic [2:0] next_irq_stat;

   function automatic logic in_window(input logic [15:0] a);
      in_window = (a >= pmr_pkg::ADDR_WIN_LO) && (a <= pmr_pkg::ADDR_WIN_HI);
   endfunction

   // Exact register match, never outside the window
   function automatic logic reg_is(input logic [15:0] a, input logic [15:0] r);
      reg_is = in_window(a) && (a == r);
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // Pins come from the analog domain, two flops each
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         wake_sync <= 2'h0;
         don_sync  <= 2'h3;
         bat_sync  <= 2'h0;
      end
      else
      begin
         wake_sync <= {wake_sync[0], wakeup_pin};
         don_sync  <= {don_sync[0], digital_regulator_on_in};
         bat_sync  <= {bat_sync[0], battery_comparator_in};
      end
   end

   // Delayed copies for edge events, read only from second stage
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         wake_q <= 1'b0;
         bat_q  <= 1'b0;
         don_q  <= 1'b1;
      end
      else
      begin
         wake_q <= wake_sync[1];
         bat_q  <= bat_sync[1];
         don_q  <= don_sync[1];
      end
   end

   // Battery drop only counts while the comparator is enabled
   assign events[pmr_pkg::IRQ_WAKE_BIT] = wake_sync[1] & ~wake_q;
   assign events[pmr_pkg::IRQ_BAT_BIT]  = ctrl.bat_on & bat_q & ~bat_sync[1];
   assign events[pmr_pkg::IRQ_DOFF_BIT] = don_q & ~don_sync[1];

   assign hit = wb_cyc_i & wb_stb_i & ~wb_ack_o & in_window(wb_adr_i);
   assign wr  = hit & wb_we_i & wb_sel_i[0];
   assign rd  = hit & ~wb_we_i;

   // Decode once here so every register block sees the same select
   assign wr_ana  = wr & reg_is(wb_adr_i, pmr_pkg::ADDR_ANALOG);
   assign wr_dig  = wr & reg_is(wb_adr_i, pmr_pkg::ADDR_DIGITAL);
   assign wr_bat  = wr & reg_is(wb_adr_i, pmr_pkg::ADDR_BATTERY);
   assign wr_mask = wr & reg_is(wb_adr_i, pmr_pkg::ADDR_IRQ_MASK);
   assign rd_stat = rd & reg_is(wb_adr_i, pmr_pkg::ADDR_IRQ_STAT);

   // One-cycle ack, also for addresses outside the window so the bus never hangs
   always_comb
   begin
      next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= next_ack;
      end
   end

   // Analog regulator control
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ctrl.ana_force <= pmr_pkg::ANA_FORCE_RST;
         ctrl.ana_on    <= pmr_pkg::ANA_ON_RST;
         ctrl.ana_trim  <= pmr_pkg::ANA_TRIM_RST;
      end
      else if (wr_ana)
      begin
         ctrl.ana_force <= wb_dat_i[pmr_pkg::ANA_FORCE_BIT];
         ctrl.ana_on    <= wb_dat_i[pmr_pkg::ANA_ON_BIT];
         ctrl.ana_trim  <= wb_dat_i[3:0];
      end
   end

   // Digital regulator control; keep-on is not readable back
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ctrl.dig_keep <= pmr_pkg::DIG_KEEP_RST;
         ctrl.dig_trim <= pmr_pkg::DIG_TRIM_RST;
      end
      else if (wr_dig)
      begin
         ctrl.dig_keep <= wb_dat_i[pmr_pkg::DIG_KEEP_BIT];
         ctrl.dig_trim <= wb_dat_i[3:2];
      end
   end

   // Battery monitor control
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         ctrl.bat_on  <= pmr_pkg::BAT_ON_RST;
         ctrl.bat_thr <= pmr_pkg::BAT_THR_RST;
      end
      else if (wr_bat)
      begin
         ctrl.bat_on  <= wb_dat_i[pmr_pkg::BAT_ON_BIT];
         ctrl.bat_thr <= wb_dat_i[4:0];
      end
   end

   // Interrupt mask
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         irq_mask <= pmr_pkg::IRQ_MASK_RST;
      end
      else if (wr_mask)
      begin
         irq_mask <= wb_dat_i[2:0];
      end
   end

   // Sticky status, cleared by read; a new event in the same cycle wins
   // so an edge landing on the clearing read is never lost
   always_comb
   begin
      if (rd_stat)
         next_irq_stat = events;
      else
         next_irq_stat = irq_stat | events;
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
         irq_stat <= 3'h0;
      else
         irq_stat <= next_irq_stat;
   end

   // Registered level output: one cycle behind status and mask
   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         irq <= 1'b0;
      end
      else
      begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Read mux; reserved bits and unused offsets give zero
   always_comb
   begin
      next_rdata = 8'h00;
      case (wb_adr_i)
         pmr_pkg::ADDR_ANALOG:
         begin
            next_rdata = {2'h0, ctrl.ana_force, ctrl.ana_on, ctrl.ana_trim};
         end
         pmr_pkg::ADDR_DIGITAL:
         begin
            // Keep-on is write-only, so its bit returns zero
            next_rdata = {wake_sync[1], 2'h0, don_sync[1], ctrl.dig_trim, 2'h0};
         end
         pmr_pkg::ADDR_BATTERY:
         begin
            next_rdata = {bat_sync[1], 1'b0, ctrl.bat_on, ctrl.bat_thr};
         end
         pmr_pkg::ADDR_IRQ_STAT:
         begin
            next_rdata = {5'h00, irq_stat};
         end
         pmr_pkg::ADDR_IRQ_MASK:
         begin
            next_rdata = {5'h00, irq_mask};
         end
         default:
         begin
            next_rdata = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      // Data only with ack; zero otherwise keeps a wired-or bus clean
      if (!rst_sync_n)
      begin
         wb_dat_o <= 8'h00;
      end
      else if (rd)
      begin
         wb_dat_o <= next_rdata;
      end
      else
      begin
         wb_dat_o <= 8'h00;
      end
   end

endmodule

/* File: sim/pmr_regs_props.sv */
// Checker: bus timing and field behaviour of the power register bank
`timescale 1ns/1ps
module pmr_regs_props
(
   // Clock and reset
   input wire logic               clk,
   input wire logic               rst_n,
   // Bus
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_we_i,
   input wire logic [15:0]        wb_adr_i,
   input wire logic [0:0]         wb_sel_i,
   input wire logic [7:0]         wb_dat_i,
   input wire logic               wb_ack_o,
   input wire logic [7:0]         wb_dat_o,
   // Analog side
   input wire logic               wakeup_pin,
   input wire logic               digital_regulator_on_in,
   input wire logic               battery_comparator_in,
   input wire pmr_pkg::pmr_ctrl_t ctrl,
   input wire logic               irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic [7:0] wd;
   logic       req, wr, rd, un, an, dg, bt;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i && wb_sel_i[0];
   assign rd = wb_ack_o && !wb_we_i;
   assign un = wb_adr_i < pmr_pkg::ADDR_WIN_LO || wb_adr_i > pmr_pkg::ADDR_WIN_HI;
   assign an = wb_adr_i == pmr_pkg::ADDR_ANALOG;
   assign dg = wb_adr_i == pmr_pkg::ADDR_DIGITAL;
   assign bt = wb_adr_i == pmr_pkg::ADDR_BATTERY;
   // Master holds data until ack, so last cycle's data is the written value
   always_ff @(posedge clk) wd <= wb_dat_i;
   ack_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one pulse");
   ana_read_a: assert property (rd && an |-> wb_dat_o[7:6] == 2'h0)
      else $error("analog reserved bits set");
   dig_read_a: assert property (rd && dg |-> wb_dat_o[6:5] == 2'h0 && wb_dat_o[1:0] == 2'h0)
      else $error("digital zero bits set");
   bat_read_a: assert property (rd && bt |-> !wb_dat_o[6])
      else $error("battery bit six set");
   gap_read_a: assert property (rd && un |-> wb_dat_o == 8'h00)
      else $error("unused offset not zero");
   gap_write_a: assert property (req && wb_we_i && un |=> $stable(ctrl))
      else $error("unused write changed controls");
   ana_write_a: assert property (wr && an |=> {ctrl.ana_force, ctrl.ana_on, ctrl.ana_trim} == wd[5:0])
      else $error("analog controls not written");
   dig_write_a: assert property (wr && dg |=> {ctrl.dig_trim, ctrl.dig_keep} == wd[3:1])
      else $error("digital controls not written");
   bat_write_a: assert property (wr && bt |=> {ctrl.bat_on, ctrl.bat_thr} == wd[5:0])
      else $error("battery controls not written");
endmodule

bind pmr_regs pmr_regs_props i_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .wakeup_pin(wakeup_pin), .digital_regulator_on_in(digital_regulator_on_in),
   .battery_comparator_in(battery_comparator_in), .ctrl(ctrl), .irq(irq));

/* File: sim/power_mgmt_control_regs_test.sv */
// Testbench: register bank scenarios with queued read checks
`timescale 1ns/1ps
module power_mgmt_control_regs_test;
   localparam logic [15:0] AN = pmr_pkg::ADDR_ANALOG, DG = pmr_pkg::ADDR_DIGITAL, BT = pmr_pkg::ADDR_BATTERY;
   logic               clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
   logic               wake = 1'b0, don = 1'b1, cmp = 1'b0;
   logic [15:0]        adr = 16'h0000;
   logic [0:0]         sel = 1'h1;
   logic [7:0]         wdat = 8'h00, rdat, d;
   pmr_pkg::pmr_ctrl_t ctrl, c;
   logic [7:0]         exp_q[$];
   int                 err_total = 0, compares = 0, i;
   always #2.5 clk = ~clk;
   pmr_regs i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat), .wakeup_pin(wake),
      .digital_regulator_on_in(don), .battery_comparator_in(cmp), .ctrl(ctrl), .irq(irq));
   task automatic chk(input string name, input logic [14:0] e, input logic [14:0] g);
      compares++;
      if (e !== g)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] v);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      n = 0;
      // Sample ack as it stood at the edge, release only after it
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      chk("ack", 15'h1, {14'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 8'h00);
   endtask
   always @(posedge clk)
      if (ack === 1'b1 && we === 1'b0)
         chk($sformatf("read %h", adr), {7'h00, exp_q.pop_front()}, {7'h00, rdat});
   task automatic results();
      $display("Compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (4000) @(posedge clk);
      err_total++;
      results();
   end
   initial
   begin
      void'($urandom(32'hBFFD7294));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ctrl", {1'b0, 1'b1, 4'h3, 1'b1, 2'h0, 1'b0, 5'h00}, ctrl);
      rd(AN, 8'h23);
      rd(DG, 8'h10);
      rd(BT, 8'h00);
      for (i = 0; i < 8; i++)
      begin
         d = 8'($urandom);
         wb(1'b1, AN, d);
         rd(AN, {2'h0, d[5:0]});
         wb(1'b1, DG, d);
         rd(DG, {4'h1, d[3:2], 2'h0});
         chk("keep", {14'h0, d[1]}, {14'h0, ctrl.dig_keep});
         wb(1'b1, BT, d);
         rd(BT, {2'h0, d[5:0]});
         c = ctrl;
         wb(1'b1, d[0] ? 16'h004D : 16'h0047, ~d);
         rd(d[0] ? 16'h0047 : 16'h004D, 8'h00);
         chk("ctrl", c, ctrl);
      end
      sel <= 1'h0;
      wb(1'b1, AN, ~d);
      sel <= 1'h1;
      rd(AN, {2'h0, d[5:0]});
      wb(1'b1, DG, 8'h02);
      wb(1'b1, BT, 8'h20);
      cmp <= 1'b1;
      wake <= 1'b1;
      repeat (4) @(posedge clk);
      rd(DG, 8'h90);
      rd(BT, 8'hA0);
      cmp <= 1'b0;
      don <= 1'b0;
      repeat (4) @(posedge clk);
      rd(DG, 8'h80);
      rd(BT, 8'h20);
      chk("irq masked", 15'h0, {14'h0, irq});
      wb(1'b1, pmr_pkg::ADDR_IRQ_MASK, 8'h02);
      repeat (2) @(posedge clk);
      chk("irq", 15'h1, {14'h0, irq});
      rd(pmr_pkg::ADDR_IRQ_STAT, 8'h07);
      repeat (2) @(posedge clk);
      chk("irq cleared", 15'h0, {14'h0, irq});
      rd(pmr_pkg::ADDR_IRQ_STAT, 8'h00);
      rd(pmr_pkg::ADDR_IRQ_MASK, 8'h02);
      repeat (3) @(posedge clk);
      results();
   end
endmodule
